// >>> design/tcl_consts.svh
`ifndef TCL_CONSTS_SVH
`define TCL_CONSTS_SVH
// register byte addresses
`define TCL_ADR_CMD 8'h00
`define TCL_ADR_STAT 8'h04
`define TCL_ADR_CNT 8'h08
// command register fields
`define TCL_CMD_CLOSE 0
`define TCL_CMD_OPEN 1
`define TCL_CMD_TYPE_LSB 2
`define TCL_CMD_RATE_LSB 5
`define TCL_CMD_CHAN_LSB 8
// status register fields
`define TCL_ST_CLOSED 0
`define TCL_ST_TYPE_LSB 2
`define TCL_ST_RATE_LSB 5
`define TCL_ST_CHAN_LSB 8
`define TCL_ST_TCH 12
`define TCL_ST_CRUN 13
`define TCL_ST_CARD 14
// reset values
`define TCL_RST_WORD 32'h0000_0000
`define TCL_RST_CNT 16'h0000
// frame and burst sizes
`define TCL_SPEECH_BITS 260
`define TCL_EFS_BITS 244
`define TCL_BURST_BITS 114
// burst loop timing, in traffic frames
`define TCL_RTD_FRAMES 4'h5
`define TCL_BUF_DEPTH 4'h8
`define TCL_REPORT_FRAMES 7'h68
`endif

// >>> design/tcl_pkg.sv
package tcl_pkg;
`include "tcl_consts.svh"
   typedef enum logic [2:0] {
      TCL_LOOP_A = 3'b000, TCL_LOOP_B = 3'b001, TCL_LOOP_C = 3'b010,
      TCL_LOOP_D = 3'b011, TCL_LOOP_E = 3'b100, TCL_LOOP_F = 3'b101
   } tcl_loop_e;
   typedef enum logic [1:0] {
      TCL_RATE_FS = 2'b00, TCL_RATE_HS = 2'b01, TCL_RATE_EFS = 2'b10
   } tcl_rate_e;
   typedef enum logic {TCL_OPEN = 1'b0, TCL_CLOSED = 1'b1} tcl_state_e;
   typedef enum logic [1:0] {
      TCL_DROP = 2'b00, TCL_PASS = 2'b01, TCL_ZERO = 2'b10
   } tcl_act_e;
   typedef enum logic [1:0] {
      TCL_BK_TCH = 2'b00, TCL_BK_SACCH = 2'b01, TCL_BK_IDLE = 2'b10
   } tcl_bkind_e;
   // decoded downlink speech or data frame
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      logic bfi;
      logic ufi;
      logic facch;
      logic [1:0] sid;
      logic [`TCL_SPEECH_BITS-1:0] bits;
   } tcl_dl_frame_s;
   // frame for the channel encoder
   typedef struct packed {
      logic valid;
      logic [`TCL_SPEECH_BITS-1:0] bits;
   } tcl_ul_frame_s;
   // deciphered burst payload, stealing flags excluded
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      tcl_bkind_e kind;
      logic [`TCL_BURST_BITS-1:0] bits;
   } tcl_burst_s;
endpackage

// >>> design/tcl_loop.sv
`timescale 1ns/100ps
`include "tcl_consts.svh"
// How it works
// R1 - close ignored without traffic or when closed
// R2 - close chosen loop, acknowledge to simulator
// R3 - simulator times close until acknowledge
// R4 - loop A passes good and data frames
// R5 - full and half rate loop 260 bits
// R6 - enhanced full rate loops 244 bits
// R7 - loop A sends zeros for bad frames
// R8 - loop A FACCH frames not looped
// R9 - loop B passes every speech frame
// R10 - simulator avoids downlink FACCH in loop B
// R11 - loop C returns 114 burst bits
// R12 - loop C ignores midamble quality
// R13 - loop C never loops SACCH or idle
// R14 - loop C running within 104 frames
// R15 - loop C fixed delay below 26
// R16 - uplink SACCH keeps its frame position
// R17 - loop D half rate passes reliable frames
// R18 - loop D zeros bad, unreliable, FACCH
// R19 - loop E passes SID 2,1; zeros 0
// R20 - loops E, F zero FACCH frames
// R21 - loop F passes only clean SID 2
// R22 - open command opens closed loop only
// R23 - settings cleared on reset, release, card
module tcl_loop (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tch_active,
   input wire logic call_release,
   input wire logic card_present,
   input wire logic frame_tick,
   input wire tcl_pkg::tcl_dl_frame_s dl_frame,
   output tcl_pkg::tcl_ul_frame_s ul_frame,
   input wire tcl_pkg::tcl_burst_s dl_burst,
   input wire logic ul_slot,
   output tcl_pkg::tcl_burst_s ul_burst,
   output logic close_ack,
   output logic open_ack_c,
   output logic loop_closed
);
   import tcl_pkg::*;

   localparam logic [`TCL_SPEECH_BITS-1:0] EFS_MASK =
      {{(`TCL_SPEECH_BITS-`TCL_EFS_BITS){1'b0}}, {`TCL_EFS_BITS{1'b1}}};

   tcl_state_e state_reg;
   tcl_loop_e type_reg;
   tcl_rate_e rate_reg;
   logic [2:0] chan_reg;
   logic [15:0] pass_cnt_reg;
   logic [15:0] zero_cnt_reg;
   logic [`TCL_BURST_BITS-1:0] bst_mem [0:7];
   logic [2:0] wr_ptr_reg;
   logic [2:0] rd_ptr_reg;
   logic [3:0] fill_reg;
   logic [3:0] fill_next;
   logic c_run_reg;
   logic [6:0] frm_cnt_reg;
   logic wr_cmd;
   logic cmd_close;
   logic cmd_open;
   logic drop_all;
   logic type_ok;
   logic close_ok;
   logic open_ok;
   logic c_on;
   logic dl_take;
   logic ul_take;
   tcl_act_e act;
   logic [`TCL_SPEECH_BITS-1:0] pass_mask;
   logic [31:0] stat_word;
   logic [2:0] cmd_type;

   // decide what a downlink frame becomes on the uplink
   function automatic tcl_act_e frame_act(input tcl_loop_e lp,
                                          input tcl_rate_e rt,
                                          input tcl_dl_frame_s f);
      tcl_act_e a;
      a = TCL_DROP;
      case (lp)
         TCL_LOOP_A: begin
            // R8 FACCH not looped
            if (f.facch)
               a = TCL_DROP;
            // R7 bad frame zeroed
            else if (f.bfi)
               a = TCL_ZERO;
            // R4 good frame looped
            else
               a = TCL_PASS;
         end
         TCL_LOOP_B: begin
            // R9 no erasure signalling
            a = f.facch ? TCL_DROP : TCL_PASS;
         end
         TCL_LOOP_D: begin
            // R17 R18 reliable only
            if (rt != TCL_RATE_HS)
               a = TCL_DROP;
            else if (f.facch || f.bfi || f.ufi)
               a = TCL_ZERO;
            else
               a = TCL_PASS;
         end
         TCL_LOOP_E: begin
            // R19 R20 SID 0 and FACCH zeroed
            if (rt != TCL_RATE_HS)
               a = TCL_DROP;
            else if (f.facch || f.sid == 2'h0)
               a = TCL_ZERO;
            else
               a = TCL_PASS;
         end
         TCL_LOOP_F: begin
            // R20 R21 valid SID only
            if (rt != TCL_RATE_HS)
               a = TCL_DROP;
            else if (!f.facch && f.sid == 2'h2 && !f.bfi && !f.ufi)
               a = TCL_PASS;
            else
               a = TCL_ZERO;
         end
         default: a = TCL_DROP;
      endcase
      return a;
   endfunction

   // bus decode: a write commits at the edge where ack is high
   assign wr_cmd = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o &&
                   wb_adr_i == `TCL_ADR_CMD && wb_sel_i[0];
   assign cmd_close = wr_cmd && wb_dat_i[`TCL_CMD_CLOSE];
   assign cmd_open = wr_cmd && wb_dat_i[`TCL_CMD_OPEN];
   assign cmd_type = wb_dat_i[`TCL_CMD_TYPE_LSB +: 3];
   assign type_ok = cmd_type <= 3'h5;
   assign drop_all = call_release || !card_present;
   // R1 refuse when idle or closed
   assign close_ok = cmd_close && tch_active && type_ok && !drop_all &&
                     state_reg == TCL_OPEN;
   // R22 open only when closed
   assign open_ok = cmd_open && !drop_all && state_reg == TCL_CLOSED;

   // loop state and stored settings
   always_ff @(posedge mclk) begin
      // R23 clear settings
      if (!reset_n || drop_all) begin
         state_reg <= TCL_OPEN;
         type_reg <= TCL_LOOP_A;
         rate_reg <= TCL_RATE_FS;
         chan_reg <= 3'h0;
      // R22 open the loop
      end else if (open_ok) begin
         state_reg <= TCL_OPEN;
         type_reg <= TCL_LOOP_A;
         rate_reg <= TCL_RATE_FS;
         chan_reg <= 3'h0;
      // R2 close requested loop
      end else if (close_ok) begin
         state_reg <= TCL_CLOSED;
         type_reg <= tcl_loop_e'(cmd_type);
         rate_reg <= tcl_rate_e'(wb_dat_i[`TCL_CMD_RATE_LSB +: 2]);
         chan_reg <= wb_sel_i[1] ? wb_dat_i[`TCL_CMD_CHAN_LSB +: 3] : 3'h0;
      end
   end

   // acknowledge pulses and the loop_closed level toward the message layer
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         close_ack <= 1'b0;
         open_ack_c <= 1'b0;
         loop_closed <= 1'b0;
      end else begin
         // R2 close acknowledge
         close_ack <= close_ok;
         open_ack_c <= open_ok && type_reg == TCL_LOOP_C;
         loop_closed <= (state_reg == TCL_CLOSED) && !drop_all &&
                        !open_ok || close_ok;
      end
   end

   // frame loops A, B, D, E, F
   assign act = frame_act(type_reg, rate_reg, dl_frame);
   // R5 R6 looped frame width
   assign pass_mask = (rate_reg == TCL_RATE_EFS) ? EFS_MASK : '1;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ul_frame <= '0;
      end else begin
         ul_frame.valid <= 1'b0;
         if (state_reg == TCL_CLOSED && dl_frame.valid &&
             dl_frame.chan == chan_reg && act != TCL_DROP) begin
            ul_frame.valid <= 1'b1;
            ul_frame.bits <= (act == TCL_PASS) ?
                             (dl_frame.bits & pass_mask) : '0;
         end
      end
   end

   // looped and zeroed frame counters, cleared on each close
   always_ff @(posedge mclk) begin
      if (!reset_n || close_ok) begin
         pass_cnt_reg <= `TCL_RST_CNT;
         zero_cnt_reg <= `TCL_RST_CNT;
      end else if (ul_frame.valid) begin
         if (ul_frame.bits == '0)
            zero_cnt_reg <= zero_cnt_reg + 16'h0001;
         else
            pass_cnt_reg <= pass_cnt_reg + 16'h0001;
      end
   end

   // burst loop C: traffic bursts only, midamble not inspected
   assign c_on = state_reg == TCL_CLOSED && type_reg == TCL_LOOP_C;
   // R11 R12 R13 take traffic bursts
   assign dl_take = c_on && dl_burst.valid && dl_burst.kind == TCL_BK_TCH &&
                    dl_burst.chan == chan_reg && fill_reg != `TCL_BUF_DEPTH;
   // R16 uplink slots skip SACCH
   assign ul_take = c_on && c_run_reg && ul_slot && fill_reg != 4'h0;
   assign fill_next = fill_reg + {3'h0, dl_take} - {3'h0, ul_take};

   // burst store, data only
   always_ff @(posedge mclk) begin
      if (dl_take)
         bst_mem[wr_ptr_reg] <= dl_burst.bits;
   end

   // pointers and fill level
   always_ff @(posedge mclk) begin
      if (!reset_n || !c_on) begin
         wr_ptr_reg <= 3'h0;
         rd_ptr_reg <= 3'h0;
         fill_reg <= 4'h0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + {2'h0, dl_take};
         rd_ptr_reg <= rd_ptr_reg + {2'h0, ul_take};
         fill_reg <= fill_next;
      end
   end

   // R15 start after fixed delay
   always_ff @(posedge mclk) begin
      if (!reset_n || !c_on)
         c_run_reg <= 1'b0;
      else if (fill_reg == `TCL_RTD_FRAMES)
         c_run_reg <= 1'b1;
   end

   // frames since close, until the burst loop runs
   always_ff @(posedge mclk) begin
      if (!reset_n || !c_on || c_run_reg)
         frm_cnt_reg <= 7'h00;
      else if (frame_tick && frm_cnt_reg != 7'h7F)
         frm_cnt_reg <= frm_cnt_reg + 7'h01;
   end

   // uplink burst toward the burst formatter
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ul_burst <= '0;
      end else begin
         ul_burst.valid <= ul_take;
         ul_burst.kind <= TCL_BK_TCH;
         ul_burst.chan <= chan_reg;
         if (ul_take)
            ul_burst.bits <= bst_mem[rd_ptr_reg];
      end
   end

   // status word
   always_comb begin
      stat_word = `TCL_RST_WORD;
      stat_word[`TCL_ST_CLOSED] = state_reg == TCL_CLOSED;
      stat_word[`TCL_ST_TYPE_LSB +: 3] = type_reg;
      stat_word[`TCL_ST_RATE_LSB +: 2] = rate_reg;
      stat_word[`TCL_ST_CHAN_LSB +: 3] = chan_reg;
      stat_word[`TCL_ST_TCH] = tch_active;
      stat_word[`TCL_ST_CRUN] = c_run_reg;
      stat_word[`TCL_ST_CARD] = card_present;
   end

   // wishbone slave: one wait state, unmapped reads give zero
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `TCL_RST_WORD;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= `TCL_RST_WORD;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            case (wb_adr_i)
               `TCL_ADR_STAT: wb_dat_o <= stat_word;
               `TCL_ADR_CNT: wb_dat_o <= {zero_cnt_reg, pass_cnt_reg};
               default: wb_dat_o <= `TCL_RST_WORD;
            endcase
         end
      end
   end

   // checks on the loop behaviour
   property p_close_refused;
      @(posedge mclk) disable iff (!reset_n)
      cmd_close && (state_reg == TCL_CLOSED || !tch_active)
      |=> !close_ack && $stable(type_reg);
   endproperty
   a_close_refused: assert property (p_close_refused) // R1
      else $error("close accepted while refused");

   property p_close_taken;
      @(posedge mclk) disable iff (!reset_n)
      close_ok |=> close_ack && loop_closed ##1 !close_ack;
   endproperty
   a_close_taken: assert property (p_close_taken) // R2
      else $error("close not taken or not acknowledged");

   property p_efs_width;
      @(posedge mclk) disable iff (!reset_n)
      ul_frame.valid && rate_reg == TCL_RATE_EFS |->
      ul_frame.bits[`TCL_SPEECH_BITS-1:`TCL_EFS_BITS] == '0;
   endproperty
   a_efs_width: assert property (p_efs_width) // R6
      else $error("enhanced frame wider than allowed");

   property p_a_bad_zero;
      @(posedge mclk) disable iff (!reset_n)
      c_on == 1'b0 && state_reg == TCL_CLOSED && type_reg == TCL_LOOP_A &&
      dl_frame.valid && dl_frame.chan == chan_reg && dl_frame.bfi &&
      !dl_frame.facch && !drop_all && !open_ok
      |=> ul_frame.valid && ul_frame.bits == '0;
   endproperty
   a_a_bad_zero: assert property (p_a_bad_zero) // R7
      else $error("bad frame in loop A not zeroed");

   property p_b_pass;
      @(posedge mclk) disable iff (!reset_n)
      state_reg == TCL_CLOSED && type_reg == TCL_LOOP_B &&
      dl_frame.valid && !dl_frame.facch && dl_frame.chan == chan_reg
      |=> ul_frame.valid && ul_frame.bits[`TCL_EFS_BITS-1:0] ==
      $past(dl_frame.bits[`TCL_EFS_BITS-1:0]);
   endproperty
   a_b_pass: assert property (p_b_pass) // R9
      else $error("loop B frame not passed");

   property p_c_only_tch;
      @(posedge mclk) disable iff (!reset_n)
      ul_burst.valid |-> $past(c_on) && ul_burst.kind == TCL_BK_TCH;
   endproperty
   a_c_only_tch: assert property (p_c_only_tch) // R13
      else $error("burst sent outside loop C");

   property p_c_start;
      @(posedge mclk) disable iff (!reset_n)
      c_on && !c_run_reg |-> frm_cnt_reg <= `TCL_REPORT_FRAMES;
   endproperty
   a_c_start: assert property (p_c_start) // R14
      else $error("loop C not running within report period");

   property p_c_delay;
      @(posedge mclk) disable iff (!reset_n)
      c_run_reg |-> fill_reg <= `TCL_RTD_FRAMES;
   endproperty
   a_c_delay: assert property (p_c_delay) // R15
      else $error("loop C delay exceeds declared value");

   property p_d_zero;
      @(posedge mclk) disable iff (!reset_n)
      state_reg == TCL_CLOSED && type_reg == TCL_LOOP_D &&
      rate_reg == TCL_RATE_HS && dl_frame.valid &&
      dl_frame.chan == chan_reg && (dl_frame.ufi || dl_frame.facch)
      |=> ul_frame.valid && ul_frame.bits == '0;
   endproperty
   a_d_zero: assert property (p_d_zero) // R18
      else $error("loop D unreliable frame not zeroed");

   property p_f_sid1;
      @(posedge mclk) disable iff (!reset_n)
      state_reg == TCL_CLOSED && type_reg == TCL_LOOP_F &&
      rate_reg == TCL_RATE_HS && dl_frame.valid &&
      dl_frame.chan == chan_reg && dl_frame.sid == 2'h1
      |=> ul_frame.valid && ul_frame.bits == '0;
   endproperty
   a_f_sid1: assert property (p_f_sid1) // R21
      else $error("loop F invalid SID not zeroed");

   property p_open;
      @(posedge mclk) disable iff (!reset_n)
      open_ok |=> state_reg == TCL_OPEN ##1 !loop_closed;
   endproperty
   a_open: assert property (p_open) // R22
      else $error("loop not opened by command");

   property p_release;
      @(posedge mclk) disable iff (!reset_n)
      call_release |=> state_reg == TCL_OPEN && type_reg == TCL_LOOP_A &&
      chan_reg == 3'h0;
   endproperty
   a_release: assert property (p_release) // R23
      else $error("settings kept after call release");

endmodule

// >>> dv/tcl_sim_model.sv
`timescale 1ns/100ps
// simulator side of the burst loop, one frame every 8 cycles
module tcl_sim_model (
   input wire logic mclk,
   input wire logic run,
   input wire tcl_pkg::tcl_burst_s ul_burst,
   output tcl_pkg::tcl_burst_s dl_burst,
   output logic ul_slot,
   output logic frame_tick,
   output int good,
   output int bad,
   output int first_ul
);
   import tcl_pkg::*;
   int cyc = 0;
   int fn = 0;
   int pos;
   logic act = 1'b0;
   logic [113:0] pat;
   logic [113:0] q[$];
   tcl_bkind_e k;
   // quiet outputs at time zero
   initial begin
      dl_burst = '0;
      ul_slot = 1'b0;
      frame_tick = 1'b0;
      good = 0;
      bad = 0;
      first_ul = -1;
   end
   // tick at slot 0, uplink slot at 1, downlink burst at 4
   always @(posedge mclk) begin
      pos = fn % 26;
      frame_tick <= (cyc == 0);
      ul_slot <= act && cyc == 1 && pos != 12 && pos != 25;
      if (run && cyc == 4) begin
         act = 1'b1;
         pat = {57'h15AC3A5, 57'(fn)};
         k = pos == 12 ? TCL_BK_SACCH : pos == 25 ? TCL_BK_IDLE : TCL_BK_TCH;
         if (k == TCL_BK_TCH) q.push_back(pat);
         dl_burst <= '{1'b1, 3'h2, k, pat};
      end else begin
         dl_burst <= '{1'b0, 3'h5, TCL_BK_IDLE, ~dl_burst.bits};
      end
      if (ul_burst.valid === 1'b1 && q.size() > 0) begin
         if (first_ul < 0) first_ul <= fn;
         if (ul_burst.bits === q[0] && ul_burst.chan === 3'h2 &&
             ul_burst.kind === TCL_BK_TCH) good <= good + 1;
         else bad <= bad + 1;
         void'(q.pop_front());
      end
      if (cyc == 7 && act) fn = fn + 1;
      if (!run) begin
         act = 1'b0;
         fn = 0;
         q.delete();
      end
      cyc = (cyc + 1) % 8;
   end
endmodule

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
   import tcl_pkg::*;
   logic mclk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic tch_active, call_release, card_present, frame_tick, ul_slot;
   logic close_ack, open_ack_c, loop_closed, run;
   tcl_dl_frame_s dl_frame;
   tcl_ul_frame_s ul_frame;
   tcl_burst_s dl_burst, ul_burst;
   int errors = 0, checked = 0, cycles = 0, n = 0;
   int good, bad, first_ul;
   logic [3:0] wsel = 4'hF;
   tcl_loop u_dut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .tch_active(tch_active),
      .call_release(call_release), .card_present(card_present),
      .frame_tick(frame_tick), .dl_frame(dl_frame), .ul_frame(ul_frame),
      .dl_burst(dl_burst), .ul_slot(ul_slot), .ul_burst(ul_burst),
      .close_ack(close_ack), .open_ack_c(open_ack_c),
      .loop_closed(loop_closed));
   tcl_sim_model u_sim (.mclk(mclk), .run(run), .ul_burst(ul_burst),
      .dl_burst(dl_burst), .ul_slot(ul_slot), .frame_tick(frame_tick),
      .good(good), .bad(bad), .first_ul(first_ul));
   // clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [259:0] got, input logic [259:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask
   // one classic bus cycle, held until ack
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= wsel;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   function automatic logic [31:0] w(logic c, logic o, logic [2:0] t,
                                     logic [1:0] r, logic [2:0] h);
      return {21'h0, h, 1'b0, r, t, o, c};
   endfunction
   function automatic logic [31:0] st(logic c, logic [2:0] t,
                                      logic [1:0] r, logic [2:0] h);
      return {17'h0, 3'b101, 1'b0, h, 1'b0, r, t, 1'b0, c};
   endfunction
   // command answered within a bounded time
   task automatic cmd(input logic [31:0] x, input int ec, input int eo);
      int a, o;
      a = 0;
      o = 0;
      wb(1'b1, 8'h00, x);
      // the pulses stand in the cycle right after the commit edge
      repeat (4) begin
         #1;
         a += (close_ack === 1'b1);
         o += (open_ack_c === 1'b1);
         @(posedge mclk);
      end
      chk(a, ec);
      chk(o, eo);
   endtask
   // one decoded frame; e: 0 none, 1 passed, 2 all zero
   task automatic frm(input logic [2:0] ch, input logic [2:0] f,
                      input logic [1:0] sid, input int e, input logic efs);
      logic [259:0] p, got;
      int seen;
      p = {26{10'h2B5}} ^ 260'(n++);
      seen = 0;
      got = '1;
      @(posedge mclk);
      dl_frame <= '{1'b1, ch, f[2], f[1], f[0], sid, p};
      @(posedge mclk);
      dl_frame <= '{1'b0, ~ch, ~f[2], ~f[1], ~f[0], ~sid, ~p};
      repeat (3) begin
         #1;
         if (ul_frame.valid === 1'b1) begin
            seen++;
            got = ul_frame.bits;
         end
         @(posedge mclk);
      end
      chk(seen, e != 0);
      if (e == 1) chk(got, efs ? {16'h0, p[243:0]} : p);
      if (e == 2) chk(got, 260'h0);
   endtask
   task automatic t_reset();
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, st(0, 0, 0, 0));
      wb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_refuse();
      tch_active <= 1'b0;
      cmd(w(1, 0, 0, 0, 1), 0, 0);
      tch_active <= 1'b1;
      card_present <= 1'b0;
      cmd(w(1, 0, 0, 0, 1), 0, 0);
      card_present <= 1'b1;
      cmd(w(1, 0, 6, 0, 1), 0, 0);
      // command byte lane not selected
      wsel = 4'h2;
      cmd(w(1, 0, 0, 0, 1), 0, 0);
      wsel = 4'hF;
   endtask
   task automatic t_loop_a();
      cmd(w(1, 0, 0, 0, 2), 1, 0);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, st(1, 0, 0, 2));
      cmd(w(1, 0, 1, 0, 3), 0, 0);
      frm(2, 3'b000, 0, 1, 0);
      frm(2, 3'b100, 0, 2, 0);
      frm(2, 3'b001, 0, 0, 0);
      frm(5, 3'b000, 0, 0, 0);
      wb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0001_0001);
      cmd(w(0, 1, 0, 0, 0), 0, 0);
      chk(loop_closed, 1'b0);
      cmd(w(0, 1, 0, 0, 0), 0, 0);
   endtask
   // no downlink FACCH while loop B is closed
   task automatic t_loop_b();
      cmd(w(1, 0, 1, 2, 0), 1, 0);
      frm(0, 3'b100, 0, 1, 1);
      frm(0, 3'b010, 2, 1, 1);
      cmd(w(0, 1, 0, 0, 0), 0, 0);
   endtask
   task automatic t_loop_d();
      cmd(w(1, 0, 3, 0, 1), 1, 0);
      frm(1, 3'b000, 0, 0, 0);
      cmd(w(0, 1, 0, 0, 0), 0, 0);
      cmd(w(1, 0, 3, 1, 1), 1, 0);
      frm(1, 3'b000, 0, 1, 0);
      frm(1, 3'b010, 0, 2, 0);
      frm(1, 3'b100, 0, 2, 0);
      frm(1, 3'b001, 0, 2, 0);
      cmd(w(0, 1, 0, 0, 0), 0, 0);
   endtask
   task automatic t_loop_ef();
      cmd(w(1, 0, 4, 1, 4), 1, 0);
      frm(4, 3'b000, 2, 1, 0);
      frm(4, 3'b000, 1, 1, 0);
      frm(4, 3'b000, 0, 2, 0);
      frm(4, 3'b001, 2, 2, 0);
      cmd(w(0, 1, 0, 0, 0), 0, 0);
      cmd(w(1, 0, 5, 1, 7), 1, 0);
      frm(7, 3'b000, 2, 1, 0);
      frm(7, 3'b000, 1, 2, 0);
      frm(7, 3'b100, 2, 2, 0);
      frm(7, 3'b010, 2, 2, 0);
      frm(7, 3'b001, 2, 2, 0);
      cmd(w(0, 1, 0, 0, 0), 0, 0);
   endtask
   // 110 frames covers the 104-frame start allowance
   task automatic t_loop_c();
      cmd(w(1, 0, 2, 0, 2), 1, 0);
      frm(2, 3'b000, 0, 0, 0);
      run <= 1'b1;
      repeat (880) @(posedge mclk);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd[13], 1'b1);
      run <= 1'b0;
      chk(first_ul, 5);
      chk(bad, 0);
      chk(good >= 90, 1);
      cmd(w(0, 1, 0, 0, 0), 0, 1);
   endtask
   task automatic t_release();
      cmd(w(1, 0, 0, 1, 6), 1, 0);
      call_release <= 1'b1;
      @(posedge mclk);
      call_release <= 1'b0;
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, st(0, 0, 0, 0));
      frm(6, 3'b000, 0, 0, 0);
   endtask
   // reset, then the scenarios
   initial begin
      reset_n = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      tch_active = 1'b1;
      call_release = 1'b0;
      card_present = 1'b1;
      dl_frame = '0;
      run = 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      t_reset();
      t_refuse();
      t_loop_a();
      t_loop_b();
      t_loop_d();
      t_loop_ef();
      t_loop_c();
      t_release();
      end_sim();
   end
endmodule
